// [hdl/pfs_pkg.sv]
// pfs_pkg: register map, field layout, reset values and carrier types
// for the pin direction and pin-function select block.
// assumes a 32-bit APB register bus and four ports of up to eight pins.
package pfs_pkg;

    // register byte offsets (one aligned word each)
    localparam logic [7:0] OFS_PORT_A_DATA = 8'h00;
    localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_PORT_B_DATA = 8'h08;
    localparam logic [7:0] OFS_PORT_B_DIRECTION = 8'h0C;
    localparam logic [7:0] OFS_PORT_C_DATA = 8'h10;
    localparam logic [7:0] OFS_PORT_C_DIRECTION = 8'h14;
    localparam logic [7:0] OFS_PORT_D_DATA = 8'h18;
    localparam logic [7:0] OFS_PORT_D_DIRECTION = 8'h1C;
    localparam logic [7:0] OFS_PORT_A_SELECT_0 = 8'h20;
    localparam logic [7:0] OFS_PORT_A_SELECT_1 = 8'h24;
    localparam logic [7:0] OFS_PORT_B_SELECT_0 = 8'h28;
    localparam logic [7:0] OFS_PORT_B_SELECT_1 = 8'h2C;
    localparam logic [7:0] OFS_PORT_C_SELECT_0 = 8'h30;
    localparam logic [7:0] OFS_PORT_C_SELECT_1 = 8'h34;
    localparam logic [7:0] OFS_PORT_D_SELECT_0 = 8'h38;
    localparam logic [7:0] OFS_INPUT_REMAP_SELECT = 8'h3C;
    localparam logic [7:0] OFS_RESET_PIN_CONTROL = 8'h40;

    // register index layout: 0..7 port data/direction, 8..15 selects, 16 reset pin control
    localparam int NUM_PORTS = 4;
    localparam int NUM_SEL = 8;
    localparam logic [5:0] IDX_SEL_BASE = 6'h08;
    localparam logic [5:0] IDX_RESET_PIN_CONTROL = 6'h10;

    // implemented pins per port (a, b, c, d)
    localparam logic [7:0] PORT_MASK [NUM_PORTS] = '{8'hFF, 8'h7F, 8'h7F, 8'h0F};
    // implemented bits of each select register, in index order
    localparam logic [7:0] SEL_MASK [NUM_SEL] =
        '{8'hCF, 8'h3F, 8'h3F, 8'h3C, 8'hFF, 8'h3F, 8'h0F, 8'hFF};

    // reset values
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_SELECT = 8'h00;
    localparam logic [7:0] RST_RESET_PIN_CONTROL = 8'h00;

    // pattern that arms the port c pin 2 field
    localparam logic [7:0] RESET_PIN_CONTROL_ARM = 8'h55;

    // two-bit field codes
    localparam logic [1:0] SEL_CODE_00 = 2'h0;
    localparam logic [1:0] SEL_CODE_01 = 2'h1;
    localparam logic [1:0] SEL_CODE_10 = 2'h2;
    localparam logic [1:0] SEL_CODE_11 = 2'h3;

    // pad bundle, port a in the low byte
    typedef struct packed {
        logic [7:0] pd;
        logic [7:0] pc;
        logic [7:0] pb;
        logic [7:0] pa;
    } pfs_pins_t;

    // outputs of the on-chip peripherals that may claim a pin
    typedef struct packed {
        logic compact_timer0_output;
        logic compact_timer1_output;
        logic periodic_timer0_output;
        logic periodic_timer1_output;
        logic periodic_timer2_output;
        logic periodic_timer3_output;
        logic serial_clock_out;
        logic serial_data_out;
        logic serial_data_line_out;
        logic serial_data_line_drive;
        logic serial_chip_select;
        logic uart_tx_out;
    } pfs_func_t;

    // pin levels routed to peripheral inputs
    typedef struct packed {
        logic [3:0] periodic_capture_in;
        logic [3:0] periodic_clock_in;
        logic [1:0] compact_clock_in;
        logic [1:0] external_interrupt_in;
        logic serial_data_in;
        logic serial_clock_in;
        logic uart_rx_in;
    } pfs_route_t;

endpackage : pfs_pkg

// [hdl/pfs_pin_mux.sv]
// pfs_pin_mux: port data latches, direction bits, pin-function select
// fields and input remapping, reached over APB.
// assumes pad inputs already synchronous to mclk_i and an outside pad ring
// that resolves pad_out_o / pad_oe_b_o into the real pin.
`timescale 1ns/100ps

module pfs_pin_mux (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pads
    input wire pfs_pkg::pfs_pins_t pad_in_i,
    output pfs_pkg::pfs_pins_t pad_out_o,
    output pfs_pkg::pfs_pins_t pad_oe_b_o,
    // peripheral side
    input wire pfs_pkg::pfs_func_t func_i,
    output pfs_pkg::pfs_route_t route_o,
    output logic [7:0] analog_sel_o,
    output logic [3:0] lcd_com_sel_o,
    output logic vref_in_sel_o,
    output logic vref_out_sel_o
);

    logic [7:0] dat_ff [pfs_pkg::NUM_PORTS];
    logic [7:0] dir_ff [pfs_pkg::NUM_PORTS];
    logic [7:0] sel_ff [pfs_pkg::NUM_SEL];
    logic [7:0] reset_pin_control_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [7:0] port_rd [pfs_pkg::NUM_PORTS];
    logic [31:0] gpio_out;
    logic [31:0] gpio_oe_b;
    logic [31:0] pad_in_vec;
    logic [5:0] idx;
    logic wr_go;
    logic [7:0] nxt_rdata;
    logic nxt_err;
    pfs_pkg::pfs_pins_t nxt_out;
    pfs_pkg::pfs_pins_t nxt_oe_b;
    pfs_pkg::pfs_route_t nxt_route;
    logic [7:0] nxt_analog;
    logic [3:0] nxt_lcd;
    logic nxt_vref_in;
    logic nxt_vref_out;
    logic [7:0] port_a_select_0;
    logic [7:0] port_a_select_1;
    logic [7:0] port_b_select_0;
    logic [7:0] port_b_select_1;
    logic [7:0] port_c_select_0;
    logic [7:0] port_c_select_1;
    logic [7:0] port_d_select_0;
    logic [7:0] remap;
    pfs_pkg::pfs_pins_t pin;

    assign idx = paddr_i[7:2];
    assign pad_in_vec = pad_in_i;
    assign pin = pad_in_i;
    // a write lands on the edge where the master sees pready high;
    // a misaligned address answers with an error and must not store
    assign wr_go = psel_i & penable_i & pready_ff & pwrite_i & (paddr_i[1:0] == 2'h0);

    assign port_a_select_0 = sel_ff[0];
    assign port_a_select_1 = sel_ff[1];
    assign port_b_select_0 = sel_ff[2];
    assign port_b_select_1 = sel_ff[3];
    assign port_c_select_0 = sel_ff[4];
    assign port_c_select_1 = sel_ff[5];
    assign port_d_select_0 = sel_ff[6];
    assign remap = sel_ff[7];

    // per port: data latch, direction bits, general io drive and read value
    genvar gp;
    generate
        for (gp = 0; gp < pfs_pkg::NUM_PORTS; gp++) begin : g_port
            always_ff @(posedge mclk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    dat_ff[gp] <= pfs_pkg::RST_DATA & pfs_pkg::PORT_MASK[gp];
                    dir_ff[gp] <= pfs_pkg::RST_DIRECTION & pfs_pkg::PORT_MASK[gp];
                end else if (wr_go && idx == 6'(2 * gp)) begin
                    dat_ff[gp] <= pwdata_i[7:0] & pfs_pkg::PORT_MASK[gp];
                end else if (wr_go && idx == 6'(2 * gp + 1)) begin
                    dir_ff[gp] <= pwdata_i[7:0] & pfs_pkg::PORT_MASK[gp];
                end
            end
            // latch drives the pin only while its direction bit is 0
            assign gpio_out[8 * gp +: 8] = dat_ff[gp];
            assign gpio_oe_b[8 * gp +: 8] = dir_ff[gp] | ~pfs_pkg::PORT_MASK[gp];
            // inputs show the pad straight through, outputs show the latch
            assign port_rd[gp] = ((dir_ff[gp] & pad_in_vec[8 * gp +: 8])
                | (~dir_ff[gp] & dat_ff[gp])) & pfs_pkg::PORT_MASK[gp];
        end
    endgenerate

    // select fields and remap register; unimplemented bits never store
    genvar gs;
    generate
        for (gs = 0; gs < pfs_pkg::NUM_SEL; gs++) begin : g_sel
            always_ff @(posedge mclk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    sel_ff[gs] <= pfs_pkg::RST_SELECT;
                end else if (wr_go && idx == pfs_pkg::IDX_SEL_BASE + 6'(gs)) begin
                    sel_ff[gs] <= pwdata_i[7:0] & pfs_pkg::SEL_MASK[gs];
                end
            end
        end
    endgenerate

    // reset-pin control word, only its exact pattern arms port c pin 2
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reset_pin_control_ff <= pfs_pkg::RST_RESET_PIN_CONTROL;
        end else if (wr_go && idx == pfs_pkg::IDX_RESET_PIN_CONTROL) begin
            reset_pin_control_ff <= pwdata_i[7:0];
        end
    end

    localparam logic [5:0] IDX_PORT_END = 6'h08;

    // read decode; unmapped words read zero and flag an error
    always_comb begin
        nxt_rdata = 8'h00;
        nxt_err = 1'b0;
        if (paddr_i[1:0] != 2'h0) begin
            nxt_err = 1'b1;
        end else if (idx < IDX_PORT_END) begin
            nxt_rdata = idx[0] ? dir_ff[idx[2:1]] : port_rd[idx[2:1]];
        end else if (idx < pfs_pkg::IDX_RESET_PIN_CONTROL) begin
            nxt_rdata = sel_ff[idx[2:0]];
        end else if (idx == pfs_pkg::IDX_RESET_PIN_CONTROL) begin
            nxt_rdata = reset_pin_control_ff;
        end else begin
            nxt_err = 1'b1;
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= nxt_err;
            prdata_ff <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, nxt_rdata};
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
    end

    // pad drive: analog/lcd first, then the peripheral, then general io.
    // a peripheral owns its pin regardless of the direction bit.
    always_comb begin
        nxt_out = gpio_out;
        nxt_oe_b = gpio_oe_b;
        nxt_analog = 8'h00;
        nxt_lcd = 4'h0;
        nxt_vref_in = 1'b0;
        nxt_vref_out = 1'b0;
        // port a pin 3
        if (port_a_select_0[7:6] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pa[3] = func_i.compact_timer1_output;
            nxt_oe_b.pa[3] = 1'b0;
        end else if (port_a_select_0[7:6] == pfs_pkg::SEL_CODE_11) begin
            nxt_lcd[0] = 1'b1;
            nxt_oe_b.pa[3] = 1'b1;
        end
        // port a pin 1
        if (port_a_select_0[3:2] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pa[1] = func_i.periodic_timer0_output;
            nxt_oe_b.pa[1] = 1'b0;
        end else if (port_a_select_0[3:2] == pfs_pkg::SEL_CODE_11) begin
            nxt_analog[7] = 1'b1;
            nxt_oe_b.pa[1] = 1'b1;
        end
        // port a pin 0, capture input stays tapped in digital codes
        if (port_a_select_0[1:0] == pfs_pkg::SEL_CODE_11) begin
            nxt_analog[6] = 1'b1;
            nxt_oe_b.pa[0] = 1'b1;
        end
        // port a pin 6
        if (port_a_select_1[5:4] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pa[6] = func_i.serial_clock_out;
            nxt_oe_b.pa[6] = 1'b0;
        end else if (port_a_select_1[5:4] == pfs_pkg::SEL_CODE_11) begin
            nxt_analog[5] = 1'b1;
            nxt_oe_b.pa[6] = 1'b1;
        end
        // port a pin 5
        if (port_a_select_1[3:2] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pa[5] = func_i.serial_data_out;
            nxt_oe_b.pa[5] = 1'b0;
        end else if (port_a_select_1[3:2] == pfs_pkg::SEL_CODE_11) begin
            nxt_analog[4] = 1'b1;
            nxt_oe_b.pa[5] = 1'b1;
        end
        // port a pin 4, the data line turns round under the serial block
        if (port_a_select_1[1:0] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pa[4] = func_i.serial_data_line_out;
            nxt_oe_b.pa[4] = ~func_i.serial_data_line_drive;
        end else if (port_a_select_1[1:0] == pfs_pkg::SEL_CODE_11) begin
            nxt_analog[3] = 1'b1;
            nxt_oe_b.pa[4] = 1'b1;
        end
        // port b pin 2
        if (port_b_select_0[5:4] == pfs_pkg::SEL_CODE_11) begin
            nxt_analog[2] = 1'b1;
            nxt_oe_b.pb[2] = 1'b1;
        end
        // port b pin 1; code 11 falls back to general io
        if (port_b_select_0[3:2] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pb[1] = func_i.serial_chip_select;
            nxt_oe_b.pb[1] = 1'b0;
        end else if (port_b_select_0[3:2] == pfs_pkg::SEL_CODE_10) begin
            nxt_vref_out = 1'b1;
            nxt_oe_b.pb[1] = 1'b1;
        end
        // port b pin 0
        if (port_b_select_0[1:0] == pfs_pkg::SEL_CODE_10) begin
            nxt_vref_in = 1'b1;
            nxt_oe_b.pb[0] = 1'b1;
        end else if (port_b_select_0[1:0] == pfs_pkg::SEL_CODE_11) begin
            nxt_analog[0] = 1'b1;
            nxt_oe_b.pb[0] = 1'b1;
        end
        // port b pin 6
        if (port_b_select_1[5:4] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pb[6] = func_i.periodic_timer2_output;
            nxt_oe_b.pb[6] = 1'b0;
        end else if (port_b_select_1[5:4] == pfs_pkg::SEL_CODE_11) begin
            nxt_lcd[2] = 1'b1;
            nxt_oe_b.pb[6] = 1'b1;
        end
        // port b pin 5
        if (port_b_select_1[3:2] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pb[5] = func_i.periodic_timer3_output;
            nxt_oe_b.pb[5] = 1'b0;
        end else if (port_b_select_1[3:2] == pfs_pkg::SEL_CODE_11) begin
            nxt_lcd[3] = 1'b1;
            nxt_oe_b.pb[5] = 1'b1;
        end
        // port c pin 3
        if (port_c_select_0[7:6] == pfs_pkg::SEL_CODE_11) begin
            nxt_lcd[2] = 1'b1;
            nxt_oe_b.pc[3] = 1'b1;
        end
        // port c pin 2 only honours its field while the reset pin is released
        if (port_c_select_0[5:4] == pfs_pkg::SEL_CODE_11
                && reset_pin_control_ff == pfs_pkg::RESET_PIN_CONTROL_ARM) begin
            nxt_out.pc[2] = func_i.compact_timer0_output;
            nxt_oe_b.pc[2] = 1'b0;
        end
        // port c pin 1
        if (port_c_select_0[3:2] == pfs_pkg::SEL_CODE_11) begin
            nxt_lcd[1] = 1'b1;
            nxt_oe_b.pc[1] = 1'b1;
        end
        // port c pin 0
        if (port_c_select_0[1:0] == pfs_pkg::SEL_CODE_11) begin
            nxt_out.pc[0] = func_i.periodic_timer1_output;
            nxt_oe_b.pc[0] = 1'b0;
        end
        // port c pins 4..6
        if (port_c_select_1[1:0] == pfs_pkg::SEL_CODE_11) begin
            nxt_lcd[3] = 1'b1;
            nxt_oe_b.pc[4] = 1'b1;
        end
        if (port_c_select_1[3:2] == pfs_pkg::SEL_CODE_01) begin
            nxt_oe_b.pc[5] = 1'b1;
        end
        if (port_c_select_1[5:4] == pfs_pkg::SEL_CODE_01) begin
            nxt_out.pc[6] = func_i.uart_tx_out;
            nxt_oe_b.pc[6] = 1'b0;
        end
        // port d pins 0 and 1
        if (port_d_select_0[3:2] == pfs_pkg::SEL_CODE_11) begin
            nxt_lcd[1] = 1'b1;
            nxt_oe_b.pd[1] = 1'b1;
        end
        if (port_d_select_0[1:0] == pfs_pkg::SEL_CODE_11) begin
            nxt_lcd[0] = 1'b1;
            nxt_oe_b.pd[0] = 1'b1;
        end
    end

    // input routing: remap bits pick the source pin; select fields never gate the route
    always_comb begin
        nxt_route = '0;
        nxt_route.periodic_capture_in[0] = remap[6] ? pin.pd[1] : pin.pa[0];
        nxt_route.periodic_capture_in[1] = pin.pb[0];
        nxt_route.periodic_capture_in[2] = remap[3] ? pin.pc[3] : pin.pa[7];
        nxt_route.periodic_capture_in[3] = remap[7] ? pin.pd[2] : pin.pb[1];
        nxt_route.periodic_clock_in[0] = pin.pc[1];
        nxt_route.periodic_clock_in[1] = remap[5] ? pin.pd[3] : pin.pb[4];
        nxt_route.periodic_clock_in[2] = remap[1] ? pin.pc[6] : pin.pa[5];
        nxt_route.periodic_clock_in[3] = remap[2] ? pin.pc[5] : pin.pb[2];
        nxt_route.compact_clock_in[0] = remap[4] ? pin.pd[0] : pin.pa[2];
        nxt_route.compact_clock_in[1] = remap[0] ? pin.pc[4] : pin.pb[3];
        nxt_route.external_interrupt_in[0] = pin.pb[0];
        nxt_route.external_interrupt_in[1] = pin.pb[2];
        nxt_route.serial_data_in = pin.pa[4];
        nxt_route.serial_clock_in = pin.pa[6];
        nxt_route.uart_rx_in = pin.pc[5];
    end

    // every output leaves from a flop; pads come up undriven
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pad_out_o <= '0;
            pad_oe_b_o <= '1;
            route_o <= '0;
            analog_sel_o <= 8'h00;
            lcd_com_sel_o <= 4'h0;
            vref_in_sel_o <= 1'b0;
            vref_out_sel_o <= 1'b0;
        end else begin
            pad_out_o <= nxt_out;
            pad_oe_b_o <= nxt_oe_b;
            route_o <= nxt_route;
            analog_sel_o <= nxt_analog;
            lcd_com_sel_o <= nxt_lcd;
            vref_in_sel_o <= nxt_vref_in;
            vref_out_sel_o <= nxt_vref_out;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;

endmodule : pfs_pin_mux

// [dv/pfs_pin_mux_checker.sv]
// pfs_pin_mux_checker: concurrent checks on the apb answer and the pad enables.
// assumes it is bound to pfs_pin_mux and sees only that module's ports.
`timescale 1ns/100ps
module pfs_pin_mux_checker (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // pads and functions
    input wire pfs_pkg::pfs_pins_t pad_oe_b_o,
    input wire logic [7:0] analog_sel_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    // one wait state, then a single-cycle answer
    ready_after_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("pready missing one cycle into the access phase");
    ready_single_a: assert property (pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    ready_needs_req_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready without an access phase");
    err_with_ready_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("pslverr outside an answer or with nonzero data");
    data_idle_zero_a: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside the answer cycle");
    // byte-wide registers: upper bits never set
    upper_bits_zero_a: assert property (prdata_o[31:8] == 24'h0)
        else $error("read data above bit 7");
    // missing pins are never driven, missing channel never chosen
    missing_pins_a: assert property (pad_oe_b_o.pb[7] && pad_oe_b_o.pc[7] &&
        pad_oe_b_o.pd[7:4] == 4'hF && !analog_sel_o[1])
        else $error("unimplemented pin driven");
    // analog functions release the digital driver
    analog_release_a: assert property (analog_sel_o[7] |-> pad_oe_b_o.pa[1])
        else $error("pa1 driven while analog");
    analog_six_release_a: assert property (analog_sel_o[6] |-> pad_oe_b_o.pa[0])
        else $error("pa0 driven while analog");
    // first edge after reset: every pin released as general io input
    reset_release_a: assert property (!$past(rst_b_i) |-> pad_oe_b_o == 32'hFFFF_FFFF)
        else $error("pins driven right after reset");

    cover property (pslverr_o);
    cover property (pready_o && !pslverr_o);
    cover property (analog_sel_o[7]);
endmodule : pfs_pin_mux_checker

bind pfs_pin_mux pfs_pin_mux_checker pfs_pin_mux_checker_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pad_oe_b_o(pad_oe_b_o), .analog_sel_o(analog_sel_o));

// [dv/pfs_pin_mux_bench.sv]
// pfs_pin_mux_bench: self-checking bench, apb register tasks and pad checks.
// assumes the checker bind file is compiled before it.
`timescale 1ns/100ps
module pfs_pin_mux_bench;
    logic mclk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic [7:0] paddr_i, a;
    logic [31:0] pwdata_i, prdata_o, rd;
    pfs_pkg::pfs_pins_t pad_in_i, pad_out_o, pad_oe_b_o;
    pfs_pkg::pfs_func_t func_i;
    pfs_pkg::pfs_route_t route_o;
    logic [7:0] analog_sel_o;
    logic [3:0] lcd_com_sel_o;
    logic vref_in_sel_o, vref_out_sel_o;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;

    pfs_pin_mux pfs_pin_mux_i (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pad_in_i(pad_in_i),
        .pad_out_o(pad_out_o), .pad_oe_b_o(pad_oe_b_o), .func_i(func_i), .route_o(route_o),
        .analog_sel_o(analog_sel_o), .lcd_com_sel_o(lcd_com_sel_o),
        .vref_in_sel_o(vref_in_sel_o), .vref_out_sel_o(vref_out_sel_o));

    // 10 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // hang guard: the sequence needs a few hundred cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer, entered right after an edge; holds until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= wd;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // idle one edge so a following setup never reassigns psel in this step
        @(posedge mclk_i);
    endtask : apb

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 32'h0);
        chk({rd[30:0], err}, {exp[30:0], 1'b0}, what);
    endtask : rd_chk

    // write a byte, then let the pads take it up before sampling
    task automatic setw(input logic [7:0] addr, input logic [7:0] v);
        apb(1'b1, addr, {24'h0, v});
        repeat (2) @(posedge mclk_i);
    endtask : setw

    initial begin
        rst_b_i = 1'b0;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        pad_in_i = 32'h0000_00E3;
        func_i = '{compact_timer0_output: 1'b1, periodic_timer1_output: 1'b1,
            periodic_timer2_output: 1'b1, default: 1'b0};
        repeat (4) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        // reset value, writable mask and clear of every select register
        for (int i = 0; i < pfs_pkg::NUM_SEL; i++) begin
            a = pfs_pkg::OFS_PORT_A_SELECT_0 + 8'(4 * i);
            rd_chk(a, 32'h0, "select reset");
            apb(1'b1, a, 32'hFFFF_FFFF);
            rd_chk(a, {24'h0, pfs_pkg::SEL_MASK[i]}, "select mask");
            apb(1'b1, a, 32'h0);
        end
        // low nibble output, high nibble input: read mixes latch and pad
        apb(1'b1, pfs_pkg::OFS_PORT_A_DATA, 32'h5A);
        apb(1'b1, pfs_pkg::OFS_PORT_A_DIRECTION, 32'hF0);
        rd_chk(pfs_pkg::OFS_PORT_A_DATA, 32'hEA, "port a read");
        repeat (2) @(posedge mclk_i);
        chk(32'(pad_oe_b_o.pa), 32'hF0, "port a enables");
        chk(32'(pad_out_o.pa[3:0]), 32'hA, "port a drive");
        // pa3 lcd, then timer output overriding a latch of 1
        setw(pfs_pkg::OFS_PORT_A_SELECT_0, 8'hC0);
        chk(32'({lcd_com_sel_o[0], pad_oe_b_o.pa[3]}), 32'h3, "pa3 lcd");
        setw(pfs_pkg::OFS_PORT_A_SELECT_0, 8'h40);
        chk(32'({pad_oe_b_o.pa[3], pad_out_o.pa[3]}), 32'h0, "pa3 timer");
        setw(pfs_pkg::OFS_PORT_A_SELECT_0, 8'h0C);
        chk(32'({analog_sel_o[7], pad_oe_b_o.pa[1]}), 32'h3, "pa1 analog");
        setw(pfs_pkg::OFS_PORT_A_SELECT_0, 8'h03);
        chk(32'({analog_sel_o[6], analog_sel_o[7]}), 32'h2, "pa0 analog");
        setw(pfs_pkg::OFS_PORT_A_SELECT_0, 8'h00);
        // pa6 analog, pa5 serial out on an input pin, pa4 analog; then swapped
        setw(pfs_pkg::OFS_PORT_A_SELECT_1, 8'h37);
        chk(32'({analog_sel_o, pad_oe_b_o.pa[6:4]}), 32'h145, "pa6..4 first");
        func_i.serial_data_line_drive <= 1'b1;
        setw(pfs_pkg::OFS_PORT_A_SELECT_1, 8'h1D);
        chk(32'({analog_sel_o, pad_oe_b_o.pa[6:4]}), 32'h82, "pa6..4 second");
        setw(pfs_pkg::OFS_PORT_A_SELECT_1, 8'h00);
        // port b: timer on an input pin, reference voltages
        setw(pfs_pkg::OFS_PORT_B_SELECT_1, 8'h10);
        chk(32'({pad_oe_b_o.pb[6], pad_out_o.pb[6]}), 32'h1, "pb6 timer");
        setw(pfs_pkg::OFS_PORT_B_SELECT_0, 8'h0A);
        chk(32'({vref_out_sel_o, vref_in_sel_o}), 32'h3, "pb vref");
        setw(pfs_pkg::OFS_PORT_B_SELECT_0, 8'h3A);
        chk(32'({analog_sel_o, pad_oe_b_o.pb[2]}), 32'h9, "pb2 analog");
        setw(pfs_pkg::OFS_PORT_B_SELECT_1, 8'h1C);
        chk(32'({lcd_com_sel_o, pad_oe_b_o.pb[5]}), 32'h11, "pb5 lcd");
        // pc2 timer only once armed; pc0 timer regardless
        apb(1'b1, pfs_pkg::OFS_PORT_C_DATA, 32'h0);
        apb(1'b1, pfs_pkg::OFS_PORT_C_DIRECTION, 32'h0);
        setw(pfs_pkg::OFS_PORT_C_SELECT_0, 8'h33);
        chk(32'(pad_out_o.pc[2:0]), 32'h1, "pc2 unarmed");
        setw(pfs_pkg::OFS_RESET_PIN_CONTROL, pfs_pkg::RESET_PIN_CONTROL_ARM);
        chk(32'(pad_out_o.pc[2:0]), 32'h5, "pc2 armed");
        // pc3 and pc1 lcd lines release output pins
        setw(pfs_pkg::OFS_PORT_C_SELECT_0, 8'hFF);
        chk(32'({lcd_com_sel_o, pad_oe_b_o.pc[3], pad_oe_b_o.pc[1]}), 32'h3B, "pc lcd");
        // timer 2 clock: pa5 high by default, pc6 low when remapped
        chk(32'(route_o.periodic_clock_in[2]), 32'h1, "clock default");
        setw(pfs_pkg::OFS_INPUT_REMAP_SELECT, 8'h02);
        chk(32'(route_o.periodic_clock_in[2]), 32'h0, "clock remapped");
        // refused accesses
        apb(1'b1, 8'h44, 32'hFF);
        chk(32'(err), 32'h1, "unmapped write");
        apb(1'b0, 8'h21, 32'h0);
        chk({rd[30:0], err}, 32'h1, "misaligned read");
        print_verdict();
    end
endmodule : pfs_pin_mux_bench
